// ### rtl/srb_bank.sv
// Purpose: bank-0 system register file 80H..FFH of an 8-bit core
// Assumes: core drives one access per cycle; read data one cycle later
// Notes: reset causes record the latest pin or supply-drop reset, cleared by the core reset
`timescale 1ns/1ps
module srb_bank #(
  parameter int CONV_W = 14
) (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_n_i,
  input wire logic supply_drop_i,
  // core access
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic bset_i,
  input wire logic bclr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // hardware sources
  input wire logic alu_flag_we_i,
  input wire logic [2:0] alu_flags_i,
  input wire logic [4:0] irq_evt_i,
  input wire logic [CONV_W-1:0] conv_result_i,
  input wire logic [1:0] port0_pins_i,
  input wire logic [7:0] port2_pins_i,
  // peripheral view
  input wire logic [7:0] peek_addr_i,
  output logic [7:0] peek_data_o,
  // core state
  output logic sys_rst_n_o,
  output logic [12:0] pc_o,
  output logic [3:0] ram_page_o,
  output logic global_irq_gate_o,
  output logic [3:0] stack_depth_o,
  output logic [2:0] flags_o,
  output logic [7:0] irq_pending_o,
  output logic [7:0] irq_mask_o
);
  logic sys_rst_n;
  srb_pkg::srb_kind_t kind;
  logic in_space;
  logic byte_wr;
  logic bit_ok;
  logic [7:0] gen_q [0:127];
  logic [7:0] special_val;
  logic [7:0] next_rdata;
  logic [7:0] next_peek;
  logic [7:0] bit_onehot;
  logic reset_cause_a;
  logic reset_cause_b;
  logic [2:0] flag_bits;
  logic [2:0] next_flags;
  logic flags_hit;
  logic [7:0] irq_pending;
  logic [7:0] irq_cpu_val;
  logic [7:0] irq_evt_bits;
  logic [7:0] next_irq;
  logic irq_hit;
  logic [7:0] conv_high;
  logic [7:0] sel_q;

  // combined reset
  assign sys_rst_n = rst_n_i & ext_rst_n_i & ~supply_drop_i;
  assign sys_rst_n_o = sys_rst_n;

  // access decode
  assign kind = srb_pkg::srb_kind(addr_i);
  assign in_space = addr_i[7];
  assign byte_wr = wr_en_i & in_space & ((kind == srb_pkg::SRB_RW) | (kind == srb_pkg::SRB_WO));
  assign bit_ok = ~wr_en_i & in_space & (kind == srb_pkg::SRB_RW);
  assign bit_onehot = 8'h01 << bit_sel_i;

  // plain registers, one per location
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++)
    begin : g_reg
      localparam logic [7:0] A = {1'b1, 7'(gi)};
      localparam logic [7:0] M = ((A == srb_pkg::ADDR_PAGE_AND_FLAGS) || (A == srb_pkg::ADDR_IRQ_PENDING)) ?
                                 8'h00 : srb_pkg::srb_mask(A);
      logic hit;
      assign hit = (addr_i == A);
      srb_reg8 #(
        .MASK(M),
        .INIT(srb_pkg::RESET_VAL)
      ) u_reg (
        .clk_sys_i(clk_sys_i),
        .sys_rst_n_i(sys_rst_n),
        .wr_i(byte_wr & hit),
        .bset_i(bit_ok & bset_i & hit),
        .bclr_i(bit_ok & bclr_i & hit),
        .bit_sel_i(bit_sel_i),
        .wdata_i(wdata_i),
        .q_o(gen_q[gi])
      );
    end
  endgenerate

  // reset causes, cleared by the core reset; a pin or supply-drop reset clears the other cause
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      reset_cause_a <= 1'b0;
      reset_cause_b <= 1'b0;
    end
    else if (supply_drop_i)
    begin
      reset_cause_a <= 1'b1;
      reset_cause_b <= 1'b0;
    end
    else if (!ext_rst_n_i)
    begin
      reset_cause_a <= 1'b0;
      reset_cause_b <= 1'b1;
    end
  end

  // arithmetic flags
  assign flags_hit = (addr_i == srb_pkg::ADDR_PAGE_AND_FLAGS);
  assign next_flags = alu_flag_we_i ? alu_flags_i :
                      (byte_wr & flags_hit) ? wdata_i[2:0] :
                      (bit_ok & bset_i & flags_hit) ? (flag_bits | bit_onehot[2:0]) :
                      (bit_ok & bclr_i & flags_hit) ? (flag_bits & ~bit_onehot[2:0]) : flag_bits;

  always_ff @(posedge clk_sys_i)
  begin
    if (!sys_rst_n)
      flag_bits <= 3'h0;
    else
      flag_bits <= next_flags;
  end

  // interrupt pending, events win over clears
  assign irq_hit = (addr_i == srb_pkg::ADDR_IRQ_PENDING);
  assign irq_evt_bits = {1'b0, irq_evt_i[4], 1'b0, irq_evt_i[3], irq_evt_i[2], 1'b0, irq_evt_i[1:0]};
  assign irq_cpu_val = (byte_wr & irq_hit) ? wdata_i :
                       (bit_ok & bset_i & irq_hit) ? (irq_pending | bit_onehot) :
                       (bit_ok & bclr_i & irq_hit) ? (irq_pending & ~bit_onehot) : irq_pending;
  assign next_irq = (irq_cpu_val | irq_evt_bits) & srb_pkg::IRQ_MASK_BITS;

  always_ff @(posedge clk_sys_i)
  begin
    if (!sys_rst_n)
      irq_pending <= srb_pkg::RESET_VAL;
    else
      irq_pending <= next_irq;
  end

  // read selection
  assign conv_high = 8'(conv_result_i[CONV_W-1:8]);
  assign sel_q = gen_q[addr_i[6:0]];
  assign special_val = (addr_i == srb_pkg::ADDR_PAGE_AND_FLAGS) ? {reset_cause_a, reset_cause_b, 3'b000, flag_bits} :
                       (addr_i == srb_pkg::ADDR_IRQ_PENDING) ? irq_pending :
                       (addr_i == srb_pkg::ADDR_CONV_RESULT_LOW) ? conv_result_i[7:0] :
                       (addr_i == srb_pkg::ADDR_CONV_RESULT_HIGH) ? conv_high :
                       (addr_i == srb_pkg::ADDR_PORT0_INPUT) ? {6'h00, port0_pins_i} :
                       (addr_i == srb_pkg::ADDR_PORT2_INPUT) ? port2_pins_i : sel_q;
  assign next_rdata = (!in_space || kind == srb_pkg::SRB_NONE || kind == srb_pkg::SRB_WO) ?
                      srb_pkg::EMPTY_READ : special_val;
  assign next_peek = peek_addr_i[7] ? gen_q[peek_addr_i[6:0]] : srb_pkg::EMPTY_READ;

  always_ff @(posedge clk_sys_i)
  begin
    if (!sys_rst_n)
    begin
      rdata_o <= srb_pkg::EMPTY_READ;
      peek_data_o <= srb_pkg::EMPTY_READ;
    end
    else
    begin
      rdata_o <= next_rdata;
      peek_data_o <= next_peek;
    end
  end

  // core state views
  assign pc_o = {gen_q[7'h4F][4:0], gen_q[7'h4E]};
  assign ram_page_o = gen_q[7'h07][3:0];
  assign global_irq_gate_o = gen_q[7'h5F][srb_pkg::GIE_BIT];
  assign stack_depth_o = gen_q[7'h5F][3:0];
  assign flags_o = flag_bits;
  assign irq_pending_o = irq_pending;
  assign irq_mask_o = gen_q[7'h49];

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking

  unmapped_read_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && in_space && kind == srb_pkg::SRB_NONE) |=> (rdata_o == 8'hFF))
    else $error("empty location did not read all ones");

  bitop_wo_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !wr_en_i && (bset_i || bclr_i) && kind == srb_pkg::SRB_WO)
      |=> (gen_q[$past(addr_i[6:0])] == $past(sel_q)))
    else $error("bit operation changed a write-only register");

  reset_init_a: assert property (disable iff (!rst_n_i)
    !sys_rst_n |=> (pc_o == 13'h0000 && ram_page_o == 4'h0 && irq_pending_o == 8'h00 && !global_irq_gate_o))
    else $error("register not at initial value after reset");

  ext_pin_a: assert property (disable iff (!rst_n_i)
    (!ext_rst_n_i && !supply_drop_i) |=> (stack_depth_o == 4'h0 && flags_o == 3'h0 && reset_cause_b))
    else $error("pin reset did not hold the registers");

  release_a: assert property (disable iff (!rst_n_i)
    ($rose(ext_rst_n_i) && sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_RAM_PAGE_SELECT)
      |=> (ram_page_o == $past(wdata_i[3:0])))
    else $error("no operation after pin release");

  supply_drop_a: assert property (disable iff (!rst_n_i)
    supply_drop_i |=> (pc_o == 13'h0000 && reset_cause_a && !reset_cause_b) ##1 (rdata_o == 8'hFF || sys_rst_n))
    else $error("supply drop did not reset the bank");

  pc_high_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_PROG_COUNTER_HIGH)
      |=> (pc_o[12:8] == $past(wdata_i[4:0])))
    else $error("program counter high byte not stored");

  stack_high_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && addr_i >= srb_pkg::ADDR_STACK_BASE && addr_i[0]) |=> (rdata_o[7:5] == 3'b000))
    else $error("return entry high byte wider than five bits");

  stack_ptr_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_STACK_POINTER)
      |=> (global_irq_gate_o == $past(wdata_i[7]) && stack_depth_o == $past(wdata_i[3:0])))
    else $error("stack pointer fields wrong");

  alu_flags_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && alu_flag_we_i) |=> (flags_o == $past(alu_flags_i)))
    else $error("flags not taken from the core");

  irq_set_wins_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && irq_evt_i[0] && wr_en_i && irq_hit && !wdata_i[0]) |=> irq_pending_o[0])
    else $error("event lost against a clear");

  conv_low_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && addr_i == srb_pkg::ADDR_CONV_RESULT_LOW) |=> (rdata_o == $past(conv_result_i[7:0])))
    else $error("converter low byte not returned");

  ro_write_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && in_space && (kind == srb_pkg::SRB_NONE || kind == srb_pkg::SRB_RO))
      |=> (gen_q[$past(addr_i[6:0])] == 8'h00))
    else $error("write changed a read-only or empty location");

  wo_read_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && kind == srb_pkg::SRB_WO) |=> (rdata_o == 8'hFF))
    else $error("write-only register did not read all ones");

  low_space_read_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !in_space) |=> (rdata_o == 8'hFF))
    else $error("address below the system space did not read all ones");

  peek_empty_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !peek_addr_i[7]) |=> (peek_data_o == 8'hFF))
    else $error("side read below the system space did not return all ones");

  bset_rw_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !wr_en_i && bset_i && addr_i == srb_pkg::ADDR_RAM_PAGE_SELECT && !bit_sel_i[2])
      |=> ram_page_o[$past(bit_sel_i[1:0])])
    else $error("bit set on a read/write register lost");

  reset_rdata_a: assert property (disable iff (!rst_n_i)
    !sys_rst_n |=> (rdata_o == 8'hFF && peek_data_o == 8'hFF))
    else $error("read data not all ones after reset");

  reset_state_a: assert property (disable iff (!rst_n_i)
    !sys_rst_n |=> (irq_mask_o == 8'h00 && flags_o == 3'h0 && stack_depth_o == 4'h0))
    else $error("core state not cleared by reset");

  pin_reset_a: assert property (disable iff (!rst_n_i)
    !ext_rst_n_i |-> !sys_rst_n_o)
    else $error("low reset pin did not hold reset");

  pin_release_a: assert property (disable iff (!rst_n_i)
    (ext_rst_n_i && !supply_drop_i) |-> sys_rst_n_o)
    else $error("reset still held after pin release");

  drop_or_a: assert property (disable iff (!rst_n_i)
    supply_drop_i |-> !sys_rst_n_o)
    else $error("supply drop did not force reset");

  pc_low_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_PROG_COUNTER_LOW)
      |=> (pc_o[7:0] == $past(wdata_i)))
    else $error("program counter low byte not stored");

  stack_low_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_STACK_BASE)
      |=> (gen_q[7'h70] == $past(wdata_i)))
    else $error("lowest return entry byte not stored");

  ram_page_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_RAM_PAGE_SELECT)
      |=> (ram_page_o == $past(wdata_i[3:0])))
    else $error("ram page field not stored");

  flags_write_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !alu_flag_we_i && wr_en_i && flags_hit)
      |=> (flags_o == $past(wdata_i[2:0])))
    else $error("flag write not stored");

  flags_clear_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && !alu_flag_we_i && !wr_en_i && !bset_i && bclr_i && flags_hit && bit_sel_i == 3'h0)
      |=> !flags_o[0])
    else $error("zero flag not cleared by bit clear");

  irq_mask_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_IRQ_MASK)
      |=> (irq_mask_o == ($past(wdata_i) & srb_pkg::IRQ_MASK_BITS)))
    else $error("enable bits not at pending positions");

  irq_event_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && irq_evt_i[4]) |=> irq_pending_o[srb_pkg::IRQ_COUNTER1_BIT])
    else $error("counter event not pending");

  conv_high_a: assert property (disable iff (!rst_n_i)
    (sys_rst_n && addr_i == srb_pkg::ADDR_CONV_RESULT_HIGH)
      |=> (rdata_o[CONV_W-9:0] == $past(conv_result_i[CONV_W-1:8])))
    else $error("converter high byte not returned");

  cover_stack_write_c: cover property (sys_rst_n && wr_en_i && addr_i == srb_pkg::ADDR_STACK_BASE);
  cover_irq_event_c: cover property (sys_rst_n && irq_evt_i[4] ##1 irq_pending_o[srb_pkg::IRQ_COUNTER1_BIT]);
  cover_drop_reset_c: cover property (supply_drop_i ##1 !supply_drop_i ##1 sys_rst_n);
  cover_bit_set_c: cover property (sys_rst_n && bit_ok && bset_i && addr_i == srb_pkg::ADDR_IRQ_MASK);
  cover_pin_reset_c: cover property (!ext_rst_n_i ##1 ext_rst_n_i ##1 sys_rst_n);

endmodule // srb_bank

// ### include/srb_pkg.sv
// Purpose: constants for the bank-0 system register bank
// Assumes: 8-bit addresses, system space 80H..FFH
// Notes: masks give the writable bits of each location
package srb_pkg;

  // register offsets
  localparam logic [7:0] ADDR_INDIRECT_LOW = 8'h80;
  localparam logic [7:0] ADDR_INDIRECT_HIGH = 8'h81;
  localparam logic [7:0] ADDR_LOOKUP_BUFFER = 8'h82;
  localparam logic [7:0] ADDR_POINTER_LOW = 8'h83;
  localparam logic [7:0] ADDR_POINTER_BANK = 8'h84;
  localparam logic [7:0] ADDR_EXTRA_WORK = 8'h85;
  localparam logic [7:0] ADDR_PAGE_AND_FLAGS = 8'h86;
  localparam logic [7:0] ADDR_RAM_PAGE_SELECT = 8'h87;
  localparam logic [7:0] ADDR_RTC_LOWCLK_OPTIONS = 8'h88;
  localparam logic [7:0] ADDR_LCD_CONTROL = 8'h89;
  localparam logic [7:0] ADDR_GAIN_AMP_CONTROL = 8'h90;
  localparam logic [7:0] ADDR_GAIN_AMP_CHANNEL = 8'h91;
  localparam logic [7:0] ADDR_GAIN_AMP_CLOCK = 8'h92;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h93;
  localparam logic [7:0] ADDR_CONVERTER_CLOCK = 8'h94;
  localparam logic [7:0] ADDR_CHARGE_PUMP_CONTROL = 8'h95;
  localparam logic [7:0] ADDR_CHARGE_PUMP_CLOCK = 8'h96;
  localparam logic [7:0] ADDR_DECIMATION_CONTROL = 8'h97;
  localparam logic [7:0] ADDR_CONV_RESULT_LOW = 8'h98;
  localparam logic [7:0] ADDR_CONV_RESULT_HIGH = 8'h99;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'hB4;
  localparam logic [7:0] ADDR_SERIAL_RELOAD = 8'hB5;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'hB6;
  localparam logic [7:0] ADDR_EDGE_SELECT = 8'hBF;
  localparam logic [7:0] ADDR_PORT1_WAKE = 8'hC0;
  localparam logic [7:0] ADDR_PORT1_DIR = 8'hC1;
  localparam logic [7:0] ADDR_PORT5_DIR = 8'hC5;
  localparam logic [7:0] ADDR_IRQ_PENDING = 8'hC8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC9;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'hCA;
  localparam logic [7:0] ADDR_COUNTER0_RELOAD = 8'hCD;
  localparam logic [7:0] ADDR_PROG_COUNTER_LOW = 8'hCE;
  localparam logic [7:0] ADDR_PROG_COUNTER_HIGH = 8'hCF;
  localparam logic [7:0] ADDR_PORT0_INPUT = 8'hD0;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'hD1;
  localparam logic [7:0] ADDR_PORT2_INPUT = 8'hD2;
  localparam logic [7:0] ADDR_PORT5_DATA = 8'hD5;
  localparam logic [7:0] ADDR_BASE_TIMER_MODE = 8'hD8;
  localparam logic [7:0] ADDR_BASE_TIMER_COUNT = 8'hD9;
  localparam logic [7:0] ADDR_COUNTER0_MODE = 8'hDA;
  localparam logic [7:0] ADDR_COUNTER0_COUNT = 8'hDB;
  localparam logic [7:0] ADDR_COUNTER1_MODE = 8'hDC;
  localparam logic [7:0] ADDR_COUNTER1_COUNT = 8'hDD;
  localparam logic [7:0] ADDR_COUNTER1_RELOAD = 8'hDE;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'hDF;
  localparam logic [7:0] ADDR_PORT0_PULLUP = 8'hE0;
  localparam logic [7:0] ADDR_PORT1_PULLUP = 8'hE1;
  localparam logic [7:0] ADDR_PORT2_PULLUP = 8'hE2;
  localparam logic [7:0] ADDR_STACK_BASE = 8'hF0;

  // field positions and values
  localparam int GIE_BIT = 7;
  localparam int CAUSE_A_BIT = 7;
  localparam int CAUSE_B_BIT = 6;
  localparam int IRQ_COUNTER1_BIT = 6;
  localparam int IRQ_BASE_TIMER_BIT = 4;
  localparam int IRQ_SERIAL_BIT = 3;
  localparam int IRQ_EXT1_BIT = 1;
  localparam int IRQ_EXT0_BIT = 0;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h5B;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] EMPTY_READ = 8'hFF;

  typedef enum logic [1:0] {
    SRB_NONE = 2'b00,
    SRB_RW = 2'b01,
    SRB_WO = 2'b10,
    SRB_RO = 2'b11
  } srb_kind_t;

  function automatic srb_kind_t srb_kind(input logic [7:0] a);
    if (a >= ADDR_STACK_BASE)
      return SRB_RW;
    case (a)
      ADDR_GAIN_AMP_CLOCK, ADDR_CONVERTER_CLOCK, ADDR_CHARGE_PUMP_CLOCK, ADDR_SERIAL_RELOAD,
      ADDR_PORT1_WAKE, ADDR_COUNTER0_RELOAD, ADDR_COUNTER1_RELOAD, ADDR_PORT0_PULLUP,
      ADDR_PORT1_PULLUP, ADDR_PORT2_PULLUP: return SRB_WO;
      ADDR_CONV_RESULT_LOW, ADDR_CONV_RESULT_HIGH, ADDR_PORT0_INPUT, ADDR_PORT2_INPUT: return SRB_RO;
      default: return (srb_mask(a) != 8'h00) ? SRB_RW : SRB_NONE;
    endcase
  endfunction

  function automatic logic [7:0] srb_mask(input logic [7:0] a);
    if (a >= ADDR_STACK_BASE)
      return a[0] ? 8'h1F : 8'hFF;
    case (a)
      ADDR_INDIRECT_LOW, ADDR_INDIRECT_HIGH, ADDR_LOOKUP_BUFFER, ADDR_POINTER_LOW,
      ADDR_POINTER_BANK, ADDR_EXTRA_WORK, ADDR_SERIAL_CONTROL, ADDR_SERIAL_RELOAD,
      ADDR_SERIAL_BUFFER, ADDR_COUNTER0_RELOAD, ADDR_PROG_COUNTER_LOW, ADDR_BASE_TIMER_MODE,
      ADDR_BASE_TIMER_COUNT, ADDR_COUNTER0_MODE, ADDR_COUNTER0_COUNT, ADDR_COUNTER1_MODE,
      ADDR_COUNTER1_COUNT, ADDR_COUNTER1_RELOAD, ADDR_PORT2_PULLUP: return 8'hFF;
      ADDR_PAGE_AND_FLAGS: return 8'h07;
      ADDR_RAM_PAGE_SELECT, ADDR_CHARGE_PUMP_CONTROL, ADDR_DECIMATION_CONTROL: return 8'h0F;
      ADDR_RTC_LOWCLK_OPTIONS: return 8'h0D;
      ADDR_LCD_CONTROL: return 8'h2D;
      ADDR_GAIN_AMP_CONTROL: return 8'h3F;
      ADDR_GAIN_AMP_CHANNEL, ADDR_CONVERTER_CONTROL: return 8'h07;
      ADDR_GAIN_AMP_CLOCK: return 8'hF8;
      ADDR_CONVERTER_CLOCK: return 8'hF5;
      ADDR_CHARGE_PUMP_CLOCK: return 8'hF9;
      ADDR_EDGE_SELECT: return 8'h98;
      ADDR_PORT1_WAKE, ADDR_PORT1_DIR, ADDR_PORT5_DIR, ADDR_PORT1_DATA, ADDR_PORT5_DATA,
      ADDR_PROG_COUNTER_HIGH, ADDR_PORT1_PULLUP: return 8'h1F;
      ADDR_IRQ_PENDING, ADDR_IRQ_MASK: return IRQ_MASK_BITS;
      ADDR_OSC_CONTROL: return 8'hFE;
      ADDR_STACK_POINTER: return 8'h8F;
      ADDR_PORT0_PULLUP: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

endpackage

// ### rtl/srb_reg8.sv
// Purpose: one masked 8-bit register with byte write and bit set/clear
// Assumes: strobes already qualified by access kind
// Notes: bits outside MASK hold zero
`timescale 1ns/1ps
module srb_reg8 #(
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic [7:0] INIT = 8'h00
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_n_i,
  // access strobes
  input wire logic wr_i,
  input wire logic bset_i,
  input wire logic bclr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] wdata_i,
  // stored value
  output logic [7:0] q_o
);
  logic [7:0] bit_onehot;
  logic [7:0] next_q;

  assign bit_onehot = 8'h01 << bit_sel_i;
  assign next_q = wr_i ? wdata_i : bset_i ? (q_o | bit_onehot) : bclr_i ? (q_o & ~bit_onehot) : q_o;

  always_ff @(posedge clk_sys_i)
  begin
    if (!sys_rst_n_i)
      q_o <= INIT & MASK;
    else
      q_o <= next_q & MASK;
  end
endmodule // srb_reg8

// ### verification/srb_core_model.sv
// Purpose: core-side model issuing one register access per call
// Assumes: called just after a rising edge; read data sampled 1 ns after the taking edge
// Notes: data lines show the inverse value when no write is made
`timescale 1ns/1ps
module srb_core_model (
  // clock
  input wire logic clk_sys_i,
  // core access
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic bset_o,
  output logic bclr_o,
  output logic [2:0] bit_sel_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    bset_o = 1'b0;
    bclr_o = 1'b0;
    bit_sel_o = 3'h0;
    wdata_o = 8'hA5;
  end

  // op 0 read, 1 byte write, 2 bit set, 3 bit clear; d[2:0] is the bit number
  task automatic xfer(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    addr_o = a;
    wr_en_o = (op == 2'h1);
    bset_o = (op == 2'h2);
    bclr_o = (op == 2'h3);
    bit_sel_o = d[2:0];
    wdata_o = (op == 2'h1) ? d : ~d;
    @(posedge clk_sys_i);
    #1;
    q = rdata_i;
  endtask
endmodule // srb_core_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the system register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected masks are written out here, not taken from the package
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i, rst_n_i, ext_rst_n_i, supply_drop_i;
  logic alu_flag_we_i;
  logic [2:0] alu_flags_i;
  logic [4:0] irq_evt_i;
  logic [13:0] conv_result_i;
  logic [1:0] port0_pins_i;
  logic [7:0] port2_pins_i, peek_addr_i;
  logic [7:0] addr, wdata, rdata, peek_data, irq_pend, irq_mask, q;
  logic wr_en, bset, bclr, sys_rst_n, global_irq_gate;
  logic [2:0] bit_sel, flags;
  logic [12:0] pc;
  logic [3:0] ram_page, depth;
  int bad_count, num_checks, cyc;
  // {always_ones, address, implemented bits}
  logic [16:0] tbl [41] = '{17'h080FF, 17'h08607, 17'h0870F, 17'h0880D, 17'h0892D, 17'h0903F, 17'h09107,
    17'h09307, 17'h0950F, 17'h0970F, 17'h0B4FF, 17'h0B6FF, 17'h0BF98, 17'h0C11F, 17'h0C51F, 17'h0C85B,
    17'h0C95B, 17'h0CAFE, 17'h0CEFF, 17'h0CF1F, 17'h0D11F, 17'h0D51F, 17'h0DF8F, 17'h0F0FF, 17'h0F11F,
    17'h0FF1F, 17'h192FF, 17'h194FF, 17'h196FF, 17'h1B5FF, 17'h1C0FF, 17'h1CDFF, 17'h1DEFF, 17'h1E0FF,
    17'h1E1FF, 17'h1E2FF, 17'h18AFF, 17'h1A0FF, 17'h1E5FF, 17'h1E6FF, 17'h140FF};

  srb_core_model i_core (.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_en_o(wr_en), .bset_o(bset), .bclr_o(bclr),
    .bit_sel_o(bit_sel), .wdata_o(wdata), .rdata_i(rdata));

  srb_bank #(.CONV_W(14)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ext_rst_n_i(ext_rst_n_i),
    .supply_drop_i(supply_drop_i), .addr_i(addr), .wr_en_i(wr_en), .bset_i(bset), .bclr_i(bclr),
    .bit_sel_i(bit_sel), .wdata_i(wdata), .rdata_o(rdata), .alu_flag_we_i(alu_flag_we_i),
    .alu_flags_i(alu_flags_i), .irq_evt_i(irq_evt_i), .conv_result_i(conv_result_i),
    .port0_pins_i(port0_pins_i), .port2_pins_i(port2_pins_i), .peek_addr_i(peek_addr_i),
    .peek_data_o(peek_data), .sys_rst_n_o(sys_rst_n), .pc_o(pc), .ram_page_o(ram_page),
    .global_irq_gate_o(global_irq_gate), .stack_depth_o(depth), .flags_o(flags), .irq_pending_o(irq_pend),
    .irq_mask_o(irq_mask));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_core.xfer(2'h0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  task automatic wr(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    i_core.xfer(op, a, d, q);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    ext_rst_n_i = 1'b1;
    supply_drop_i = 1'b0;
    alu_flag_we_i = 1'b0;
    alu_flags_i = 3'h0;
    irq_evt_i = 5'h00;
    conv_result_i = 14'h2A5C;
    port0_pins_i = 2'h2;
    port2_pins_i = 8'hC3;
    peek_addr_i = 8'h92;
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    // reset values and empty or write-only locations
    foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][16] ? 8'hFF : 8'h00);
    chk({3'h0, pc}, 16'h0000);
    // bit set on a write-only location leaves it untouched
    wr(2'h2, 8'h92, 8'h03);
    rd(8'h87, 8'h00);
    chk({8'h00, peek_data}, 16'h0000);
    wr(2'h2, 8'h87, 8'h02);
    rd(8'h87, 8'h04);
    // read-only and pin locations
    wr(2'h1, 8'h98, 8'h00);
    rd(8'h98, 8'h5C);
    rd(8'h99, 8'h2A);
    rd(8'hD0, 8'h02);
    rd(8'hD2, 8'hC3);
    // all ones written to every table location, implemented bits read back, all ones where always_ones is set
    foreach (tbl[i]) wr(2'h1, tbl[i][15:8], 8'hFF);
    foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][7:0]);
    chk({3'h0, pc}, 16'h1FFF);
    chk({7'h00, global_irq_gate, 4'h0, depth}, 16'h010F);
    chk({12'h000, ram_page}, 16'h000F);
    chk({irq_pend, irq_mask}, 16'h5B5B);
    chk({8'h00, peek_data}, 16'h00F8);
    wr(2'h3, 8'h92, 8'h03);
    wr(2'h3, 8'h87, 8'h01);
    rd(8'h87, 8'h0D);
    chk({8'h00, peek_data}, 16'h00F8);
    // program counter and return entry pairing
    peek_addr_i = 8'h40;
    wr(2'h1, 8'hCE, 8'h34);
    wr(2'h1, 8'hCF, 8'hEA);
    rd(8'hCF, 8'h0A);
    chk({8'h00, peek_data}, 16'h00FF);
    chk({3'h0, pc}, 16'h0A34);
    wr(2'h1, 8'hF0, 8'h5A);
    rd(8'hF0, 8'h5A);
    rd(8'hFE, 8'h00);
    // events beat a clearing write in the same cycle
    irq_evt_i = 5'h15;
    wr(2'h1, 8'hC8, 8'h00);
    irq_evt_i = 5'h00;
    rd(8'hC8, 8'h49);
    chk({8'h00, irq_pend}, 16'h0049);
    irq_evt_i = 5'h0A;
    wr(2'h3, 8'hC8, 8'h00);
    irq_evt_i = 5'h00;
    rd(8'hC8, 8'h5A);
    // ALU flag update beats a CPU write
    alu_flag_we_i = 1'b1;
    alu_flags_i = 3'h5;
    wr(2'h1, 8'h86, 8'h02);
    alu_flag_we_i = 1'b0;
    rd(8'h86, 8'h05);
    chk({13'h0000, flags}, 16'h0005);
    wr(2'h3, 8'h86, 8'h00);
    rd(8'h86, 8'h04);
    // external pin reset for one edge
    ext_rst_n_i = 1'b0;
    rd(8'h86, 8'hFF);
    chk({15'h0000, sys_rst_n}, 16'h0000);
    chk({12'h000, ram_page}, 16'h0000);
    ext_rst_n_i = 1'b1;
    wr(2'h1, 8'h87, 8'h06);
    chk({15'h0000, sys_rst_n}, 16'h0001);
    rd(8'h86, 8'h40);
    rd(8'h87, 8'h06);
    chk({3'h0, pc}, 16'h0000);
    chk({irq_pend, irq_mask}, 16'h0000);
    // supply drop alone resets as well
    supply_drop_i = 1'b1;
    rd(8'h86, 8'hFF);
    chk({15'h0000, sys_rst_n}, 16'h0000);
    supply_drop_i = 1'b0;
    rd(8'h86, 8'h80);
    rd(8'hDF, 8'h00);
    // core reset clears the reset causes
    rst_n_i = 1'b0;
    rd(8'h86, 8'hFF);
    rst_n_i = 1'b1;
    rd(8'h86, 8'h00);
    test_done();
  end
endmodule // tb_top
